/* rtl/mtpr_regs.sv */
`timescale 1ns/100ps
`default_nettype none

// How it works
// - All registers reached through register handshake only.
// - Commands run only while code word held.
// - Command 0x7000 restores delivery parameter values.
// - Terminal type register is fixed, read-only.
// - Firmware version is two ASCII bytes, read-only.
// - Hardware and special version read as words.
// - User register writes rejected without code word.
// - Restart clears the stored code word.
// - Feature bit 2 set disables the watchdog.
// - Feature bit 0 set enables user scaling.
// - Scaling adds the offset register value.
// - Gain factor has 256 meaning one.
// - Watchdog timeout counts in 10 ms units.
// - Bus error, nonzero value: output on-fallback.
// - Bus error, zero value: output off-fallback.
// - Control method 0, 1, or 2 if firmware allows.
// - Short circuit: stay off or restart per register.
// - Line frequency register selects 50 or 60 Hz.
// - Output word ignored on read, carries write data.
// - Read answer echoes control byte, returns value.
// - Write answer clears bit 6, word invalid.
// - Other code word value re-arms write protection.
// - Status bit 7 acknowledges, bits 5..0 register number.
module mtpr_regs #(
    parameter int          TICK_CYCLES  = mtpr_pkg::WDOG_TICK_CYCLES,
    parameter logic [15:0] TYPE_ID      = 16'h0123, // Arbitrary value.
    parameter logic [15:0] FW_VERSION   = 16'h3242, // Arbitrary value.
    parameter logic [15:0] SPECIAL_ID   = 16'h0000, // Arbitrary value.
    parameter logic [15:0] HW_VER_RESET = 16'h0000
) (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_cycle_strobe,
    input  wire logic [7:0]  i_host_control_byte,
    input  wire logic [15:0] i_host_output_word,
    input  wire logic [15:0] i_process_value,
    input  wire logic        i_short_circuit,
    output logic      [7:0]  o_device_status_byte,
    output logic      [15:0] o_device_input_word,
    output logic      [15:0] o_control_value,
    output logic             o_fieldbus_error,
    output logic             o_watchdog_disable,
    output logic             o_user_scaling_on,
    output logic      [1:0]  o_control_method,
    output logic             o_line_frequency_60hz,
    output logic             o_stage_enable
);

    logic [15:0]           command_trigger;
    logic [15:0]           hardware_version;
    logic [15:0]           protection_code_word;
    logic [15:0]           feature_config;
    logic [15:0]           scaling_offset;
    logic [15:0]           scaling_gain;
    logic [15:0]           spare_param;
    logic [15:0]           watchdog_timeout;
    logic [15:0]           fallback_value_on;
    logic [15:0]           fallback_value_off;
    logic [15:0]           control_method;
    logic [15:0]           short_circuit_behaviour;
    logic [15:0]           line_frequency_select;
    logic                  reg_access;
    logic                  reg_write;
    logic                  reg_read;
    logic                  unlocked;
    logic [5:0]            reg_num;
    logic                  restore;
    logic [31:0]           div_cnt;
    logic                  tick;
    logic [15:0]           elapsed;
    logic [31:0]           product;
    logic [15:0]           next_control_value;
    mtpr_pkg::mtpr_stage_t stage;

    // Decode of one register exchange per fieldbus cycle.
    assign reg_access = i_cycle_strobe
                        & i_host_control_byte[mtpr_pkg::CB_ACCESS_BIT];
    assign reg_write  = reg_access
                        & i_host_control_byte[mtpr_pkg::CB_WRITE_BIT];
    assign reg_read   = reg_access
                        & ~i_host_control_byte[mtpr_pkg::CB_WRITE_BIT];
    assign reg_num    = i_host_control_byte[5:0];
    assign unlocked   = (protection_code_word == mtpr_pkg::CODE_WORD);
    assign restore    = reg_write & unlocked
                        & (reg_num == mtpr_pkg::REG_COMMAND)
                        & (i_host_output_word == mtpr_pkg::CMD_RESTORE);

    // Read multiplexer; unmapped numbers read as zero.
    function automatic logic [15:0] read_value(input logic [5:0] num);
        case (num)
            mtpr_pkg::REG_COMMAND:      read_value = command_trigger;
            mtpr_pkg::REG_TYPE_ID:      read_value = TYPE_ID;
            mtpr_pkg::REG_FIRMWARE:     read_value = FW_VERSION;
            mtpr_pkg::REG_HW_VERSION:   read_value = hardware_version;
            mtpr_pkg::REG_SPECIAL:      read_value = SPECIAL_ID;
            mtpr_pkg::REG_CODE_WORD:    read_value = protection_code_word;
            mtpr_pkg::REG_FEATURE:      read_value = feature_config;
            mtpr_pkg::REG_SCALE_OFFSET: read_value = scaling_offset;
            mtpr_pkg::REG_SCALE_GAIN:   read_value = scaling_gain;
            mtpr_pkg::REG_SPARE:        read_value = spare_param;
            mtpr_pkg::REG_WDOG_TIMEOUT: read_value = watchdog_timeout;
            mtpr_pkg::REG_FALLBACK_ON:  read_value = fallback_value_on;
            mtpr_pkg::REG_FALLBACK_OFF: read_value = fallback_value_off;
            mtpr_pkg::REG_CTRL_METHOD:  read_value = control_method;
            mtpr_pkg::REG_SHORT_BEHAV:  read_value = short_circuit_behaviour;
            mtpr_pkg::REG_LINE_FREQ:    read_value = line_frequency_select;
            default:                    read_value = 16'h0000;
        endcase
    endfunction

    // Answer to each exchange: status byte and input word.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_device_status_byte <= 8'h00;
            o_device_input_word  <= 16'h0000;
        end else if (reg_write) begin
            o_device_status_byte <= {1'b1, 1'b0, reg_num};
        end else if (reg_read) begin
            o_device_status_byte <= i_host_control_byte;
            o_device_input_word  <= read_value(reg_num);
        end else if (i_cycle_strobe) begin
            o_device_status_byte <= 8'h00;
        end
    end

    // The code word is writable at all times and cleared by restart.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            protection_code_word <= mtpr_pkg::RST_CODE_WORD;
        end else if (reg_write && reg_num == mtpr_pkg::REG_CODE_WORD) begin
            protection_code_word <= i_host_output_word;
        end
    end

    // Hardware version is a user register without a delivery value.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hardware_version <= HW_VER_RESET;
        end else if (reg_write && unlocked
                     && reg_num == mtpr_pkg::REG_HW_VERSION) begin
            hardware_version <= i_host_output_word;
        end
    end

    // Parameter registers: protected writes and delivery restore.
    always_ff @(posedge i_clk) begin
        if (i_srst || restore) begin
            scaling_offset          <= mtpr_pkg::RST_SCALE_OFFSET;
            scaling_gain            <= mtpr_pkg::RST_SCALE_GAIN;
            spare_param             <= mtpr_pkg::RST_SPARE;
            watchdog_timeout        <= mtpr_pkg::RST_WDOG_TIMEOUT;
            fallback_value_on       <= mtpr_pkg::RST_FALLBACK_ON;
            fallback_value_off      <= mtpr_pkg::RST_FALLBACK_OFF;
            control_method          <= mtpr_pkg::RST_CTRL_METHOD;
            short_circuit_behaviour <= mtpr_pkg::RST_SHORT_BEHAV;
            line_frequency_select   <= mtpr_pkg::RST_LINE_FREQ;
        end else if (reg_write && unlocked) begin
            case (reg_num)
                mtpr_pkg::REG_SCALE_OFFSET: begin
                    scaling_offset <= i_host_output_word;
                end
                mtpr_pkg::REG_SCALE_GAIN: begin
                    scaling_gain <= i_host_output_word;
                end
                mtpr_pkg::REG_SPARE: begin
                    spare_param <= i_host_output_word;
                end
                mtpr_pkg::REG_WDOG_TIMEOUT: begin
                    watchdog_timeout <= i_host_output_word;
                end
                mtpr_pkg::REG_FALLBACK_ON: begin
                    fallback_value_on <= i_host_output_word;
                end
                mtpr_pkg::REG_FALLBACK_OFF: begin
                    fallback_value_off <= i_host_output_word;
                end
                mtpr_pkg::REG_CTRL_METHOD: begin
                    // Leading edge needs a recent enough firmware.
                    if (i_host_output_word == mtpr_pkg::METHOD_FULL_WAVE
                        || i_host_output_word == mtpr_pkg::METHOD_MIXED
                        || (i_host_output_word == mtpr_pkg::METHOD_LEADING
                            && FW_VERSION[15:8]
                               >= mtpr_pkg::FW_LEADING_MIN)) begin
                        control_method <= i_host_output_word;
                    end
                end
                mtpr_pkg::REG_SHORT_BEHAV: begin
                    if (i_host_output_word[15:1] == 15'h0000) begin
                        short_circuit_behaviour <= i_host_output_word;
                    end
                end
                mtpr_pkg::REG_LINE_FREQ: begin
                    if (i_host_output_word[15:1] == 15'h0000) begin
                        line_frequency_select <= i_host_output_word;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Command and feature registers; reserved feature bits stay zero.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            command_trigger <= mtpr_pkg::RST_COMMAND;
            feature_config  <= mtpr_pkg::RST_FEATURE;
        end else if (reg_write && unlocked) begin
            if (reg_num == mtpr_pkg::REG_COMMAND) begin
                command_trigger <= i_host_output_word;
            end
            if (reg_num == mtpr_pkg::REG_FEATURE) begin
                feature_config <= i_host_output_word
                                  & mtpr_pkg::FEATURE_MASK;
            end
        end
    end

    // Tick divider restarted by every bus update.
    assign tick = (div_cnt == 32'(TICK_CYCLES - 1));

    always_ff @(posedge i_clk) begin
        if (i_srst || i_cycle_strobe || tick) begin
            div_cnt <= 32'h0000_0000;
        end else begin
            div_cnt <= div_cnt + 32'h0000_0001;
        end
    end

    // Ticks elapsed since the last bus update, saturating.
    always_ff @(posedge i_clk) begin
        if (i_srst || i_cycle_strobe) begin
            elapsed <= 16'h0000;
        end else if (tick && elapsed != 16'hffff) begin
            elapsed <= elapsed + 16'h0001;
        end
    end

    // Bus error once the timeout is reached, unless disabled.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_fieldbus_error <= 1'b0;
        end else begin
            o_fieldbus_error <= ~feature_config[mtpr_pkg::FEAT_WDOG_DIS_BIT]
                                & (watchdog_timeout != 16'h0000)
                                & (elapsed >= watchdog_timeout);
        end
    end

    // Control value: fallback, scaled, or passed straight through.
    assign product = 32'(i_process_value) * 32'(scaling_gain);

    always_comb begin
        if (o_fieldbus_error) begin
            if (i_process_value != 16'h0000) begin
                next_control_value = fallback_value_on;
            end else begin
                next_control_value = fallback_value_off;
            end
        end else if (feature_config[mtpr_pkg::FEAT_SCALE_BIT]) begin
            next_control_value = product[mtpr_pkg::GAIN_FRAC_BITS +: 16]
                                 + scaling_offset;
        end else begin
            next_control_value = i_process_value;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_control_value <= 16'h0000;
        end else begin
            o_control_value <= next_control_value;
        end
    end

    // Power stage trips on a short and may restart when it clears.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stage <= mtpr_pkg::STAGE_RUN;
        end else begin
            case (stage)
                mtpr_pkg::STAGE_RUN: begin
                    if (i_short_circuit) begin
                        stage <= mtpr_pkg::STAGE_TRIPPED;
                    end
                end
                mtpr_pkg::STAGE_TRIPPED: begin
                    if (!i_short_circuit && short_circuit_behaviour
                        == mtpr_pkg::SHORT_RESTART) begin
                        stage <= mtpr_pkg::STAGE_RUN;
                    end
                end
                default: begin
                    stage <= mtpr_pkg::STAGE_TRIPPED;
                end
            endcase
        end
    end

    // Configuration levels for the power stage.
    assign o_stage_enable        = (stage == mtpr_pkg::STAGE_RUN);
    assign o_watchdog_disable    = feature_config[mtpr_pkg::FEAT_WDOG_DIS_BIT];
    assign o_user_scaling_on     = feature_config[mtpr_pkg::FEAT_SCALE_BIT];
    assign o_control_method      = control_method[1:0];
    assign o_line_frequency_60hz = line_frequency_select[0];

    // Read answers echo the control byte and return the register.
    property p_read_echo;
        @(posedge i_clk) disable iff (i_srst)
        reg_read |=> o_device_status_byte == $past(i_host_control_byte)
                     && o_device_input_word == $past(read_value(reg_num));
    endproperty
    a_read_echo: assert property (p_read_echo)
        else $error("Read answer does not echo control byte.");

    // Write answers acknowledge with bit 6 cleared.
    property p_write_ack;
        @(posedge i_clk) disable iff (i_srst)
        reg_write |=> o_device_status_byte
                      == ($past(i_host_control_byte) & 8'hbf);
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("Write answer status byte is wrong.");

    // Locked writes leave the feature register alone.
    property p_locked_reject;
        @(posedge i_clk) disable iff (i_srst)
        reg_write && !unlocked && reg_num == mtpr_pkg::REG_FEATURE
        |=> $stable(feature_config);
    endproperty
    a_locked_reject: assert property (p_locked_reject)
        else $error("Feature register changed while locked.");

    // Restore command lands the gain, timeout, on-fallback, spare and short-circuit delivery values.
    property p_restore;
        @(posedge i_clk) disable iff (i_srst)
        restore |=> scaling_gain == mtpr_pkg::RST_SCALE_GAIN
                    && watchdog_timeout == mtpr_pkg::RST_WDOG_TIMEOUT
                    && fallback_value_on == mtpr_pkg::RST_FALLBACK_ON
                    && spare_param == mtpr_pkg::RST_SPARE
                    && short_circuit_behaviour == mtpr_pkg::RST_SHORT_BEHAV;
    endproperty
    a_restore: assert property (p_restore)
        else $error("Restore command did not restore defaults.");

    // Restore command is ignored while locked.
    property p_cmd_locked;
        @(posedge i_clk) disable iff (i_srst)
        reg_write && !unlocked && reg_num == mtpr_pkg::REG_COMMAND
        |=> $stable(scaling_gain) && $stable(watchdog_timeout);
    endproperty
    a_cmd_locked: assert property (p_cmd_locked)
        else $error("Command executed without code word.");

    // Protection is armed right after reset.
    property p_code_cleared;
        @(posedge i_clk) disable iff (i_srst)
        $fell(i_srst) |-> !unlocked;
    endproperty
    a_code_cleared: assert property (p_code_cleared)
        else $error("Code word survived a restart.");

    // Any other code value re-arms protection.
    property p_rearm;
        @(posedge i_clk) disable iff (i_srst)
        reg_write && reg_num == mtpr_pkg::REG_CODE_WORD
        && i_host_output_word != mtpr_pkg::CODE_WORD |=> !unlocked;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("Protection not re-armed by other code value.");

    // Fallback on a nonzero value.
    property p_fallback_on;
        @(posedge i_clk) disable iff (i_srst)
        o_fieldbus_error && i_process_value != 16'h0000
        |=> o_control_value == $past(fallback_value_on);
    endproperty
    a_fallback_on: assert property (p_fallback_on)
        else $error("On-fallback value not output.");

    // Fallback on a zero value.
    property p_fallback_off;
        @(posedge i_clk) disable iff (i_srst)
        o_fieldbus_error && i_process_value == 16'h0000
        |=> o_control_value == $past(fallback_value_off);
    endproperty
    a_fallback_off: assert property (p_fallback_off)
        else $error("Off-fallback value not output.");

    // A disabled watchdog never reports an error.
    property p_wdog_disable;
        @(posedge i_clk) disable iff (i_srst)
        feature_config[mtpr_pkg::FEAT_WDOG_DIS_BIT] |=> !o_fieldbus_error;
    endproperty
    a_wdog_disable: assert property (p_wdog_disable)
        else $error("Bus error raised with watchdog disabled.");

    // Reserved feature bits always read zero.
    property p_feat_reserved;
        @(posedge i_clk) disable iff (i_srst)
        (feature_config & ~mtpr_pkg::FEATURE_MASK) == 16'h0000;
    endproperty
    a_feat_reserved: assert property (p_feat_reserved)
        else $error("Reserved feature bits set.");

endmodule

`default_nettype wire

/* shared/mtpr_pkg.sv */
package mtpr_pkg;

    // Register numbers carried in the low six bits of the control byte.
    localparam logic [5:0]  REG_COMMAND        = 6'h07;
    localparam logic [5:0]  REG_TYPE_ID        = 6'h08;
    localparam logic [5:0]  REG_FIRMWARE       = 6'h09;
    localparam logic [5:0]  REG_HW_VERSION     = 6'h10;
    localparam logic [5:0]  REG_SPECIAL        = 6'h1d;
    localparam logic [5:0]  REG_CODE_WORD      = 6'h1f;
    localparam logic [5:0]  REG_FEATURE        = 6'h20;
    localparam logic [5:0]  REG_SCALE_OFFSET   = 6'h21;
    localparam logic [5:0]  REG_SCALE_GAIN     = 6'h22;
    localparam logic [5:0]  REG_SPARE          = 6'h23;
    localparam logic [5:0]  REG_WDOG_TIMEOUT   = 6'h24;
    localparam logic [5:0]  REG_FALLBACK_ON    = 6'h25;
    localparam logic [5:0]  REG_FALLBACK_OFF   = 6'h26;
    localparam logic [5:0]  REG_CTRL_METHOD    = 6'h27;
    localparam logic [5:0]  REG_SHORT_BEHAV    = 6'h28;
    localparam logic [5:0]  REG_LINE_FREQ      = 6'h29;

    // Control and status byte layout.
    localparam int          CB_ACCESS_BIT      = 7;
    localparam int          CB_WRITE_BIT       = 6;

    // Feature register fields.
    localparam int          FEAT_SCALE_BIT     = 0;
    localparam int          FEAT_WDOG_DIS_BIT  = 2;
    localparam logic [15:0] FEATURE_MASK       = 16'h0005;

    // Protection code word and command values.
    localparam logic [15:0] CODE_WORD          = 16'h1235;
    localparam logic [15:0] CMD_RESTORE        = 16'h7000;

    // Reset and delivery values.
    localparam logic [15:0] RST_COMMAND        = 16'h0000;
    localparam logic [15:0] RST_CODE_WORD      = 16'h0000;
    localparam logic [15:0] RST_FEATURE        = 16'h0000;
    localparam logic [15:0] RST_SCALE_OFFSET   = 16'h0000;
    localparam logic [15:0] RST_SCALE_GAIN     = 16'h0100;
    localparam logic [15:0] RST_SPARE          = 16'h0003;
    localparam logic [15:0] RST_WDOG_TIMEOUT   = 16'h000a;
    localparam logic [15:0] RST_FALLBACK_ON    = 16'h3fff;
    localparam logic [15:0] RST_FALLBACK_OFF   = 16'h0000;
    localparam logic [15:0] RST_CTRL_METHOD    = 16'h0000;
    localparam logic [15:0] RST_SHORT_BEHAV    = 16'h0001;
    localparam logic [15:0] RST_LINE_FREQ      = 16'h0000;

    // Control methods and firmware level needed for leading-edge control.
    localparam logic [15:0] METHOD_FULL_WAVE   = 16'h0000;
    localparam logic [15:0] METHOD_MIXED       = 16'h0001;
    localparam logic [15:0] METHOD_LEADING     = 16'h0002;
    localparam logic [7:0]  FW_LEADING_MIN     = 8'h32;
    localparam logic [15:0] SHORT_RESTART      = 16'h0001;

    // Gain is fixed point with eight fraction bits.
    localparam int          GAIN_FRAC_BITS     = 8;

    // Watchdog tick of 10 ms at a 40 MHz clock.
    localparam int          CLK_HZ             = 40000000;
    localparam int          WDOG_TICK_MS       = 10;
    localparam int          WDOG_TICK_CYCLES   = CLK_HZ / 1000 * WDOG_TICK_MS;

    // Power stage state after a short circuit.
    typedef enum logic [0:0] {
        STAGE_RUN     = 1'b0,
        STAGE_TRIPPED = 1'b1
    } mtpr_stage_t;

endpackage

/* testbench/mtpr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module mtpr_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_go,
    input  wire logic [7:0]  i_cb,
    input  wire logic [15:0] i_word,
    output logic             o_strobe,
    output logic      [7:0]  o_cb,
    output logic      [15:0] o_word
);
    // Sends one image per request; between images the bytes toggle.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_strobe <= 1'b0;
            o_cb     <= 8'h00;
            o_word   <= 16'h0000;
        end else begin
            o_strobe <= i_go;
            o_cb     <= i_go ? i_cb : ~o_cb;
            o_word   <= i_go ? i_word : ~o_word;
        end
    end
endmodule

`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        go = 1'b0;
    logic [7:0]  cb = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [15:0] pv = 16'h0000;
    logic        sc = 1'b0;
    logic        stb, fe, wdis, uscl, f60, sten;
    logic [7:0]  hcb, sb;
    logic [15:0] hw, iw, cv, r;
    logic [1:0]  meth;
    int          errors = 0;
    int          samples_checked = 0;
    int          seed = 32'h239d931d;
    logic [5:0]  regs [16] = '{6'h07, 6'h08, 6'h09, 6'h10, 6'h1d, 6'h1f,
        6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29};

    // Clock of 25 ns.
    always #12.5 i_clk = ~i_clk;

    // Controller model and the register bank.
    mtpr_host_model i_host (.i_clk(i_clk), .i_srst(i_srst), .i_go(go),
        .i_cb(cb), .i_word(wd), .o_strobe(stb), .o_cb(hcb), .o_word(hw));
    mtpr_regs #(.TICK_CYCLES(4)) i_dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_cycle_strobe(stb), .i_host_control_byte(hcb),
        .i_host_output_word(hw), .i_process_value(pv),
        .i_short_circuit(sc), .o_device_status_byte(sb),
        .o_device_input_word(iw), .o_control_value(cv),
        .o_fieldbus_error(fe), .o_watchdog_disable(wdis),
        .o_user_scaling_on(uscl), .o_control_method(meth),
        .o_line_frequency_60hz(f60), .o_stage_enable(sten));

    // Delivery value of each register; identity values are arbitrary.
    function automatic logic [15:0] dflt(input logic [5:0] a);
        case (a)
            6'h08: dflt = 16'h0123;
            6'h09: dflt = 16'h3242;
            6'h22: dflt = 16'h0100;
            6'h23: dflt = 16'h0003;
            6'h24: dflt = 16'h000a;
            6'h25: dflt = 16'h3fff;
            6'h28: dflt = 16'h0001;
            default: dflt = 16'h0000;
        endcase
    endfunction

    // Gain has eight fraction bits, offset is added with wrap.
    function automatic logic [15:0] scl(input logic [15:0] v, g, o);
        logic [31:0] p;
        p = v * g;
        return p[23:8] + o;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One image, held for one strobe; answer sampled mid-cycle.
    task automatic xfer(input logic [7:0] c, input logic [15:0] d);
        @(posedge i_clk);
        go <= 1'b1;
        cb <= c;
        wd <= d;
        @(posedge i_clk);
        go <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        r = $random(seed);
        xfer({2'b10, a}, r);
        chk(sb, {2'b10, a});
        chk(iw, e);
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        xfer({2'b11, a}, d);
        chk(sb, {2'b10, a});
    endtask

    task automatic wait_cv(input logic [15:0] v);
        @(posedge i_clk);
        pv <= v;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic final_report;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        foreach (regs[k]) begin
            rd(regs[k], dflt(regs[k]));
        end
        wr(6'h21, 16'h1111);
        rd(6'h21, 16'h0000);
        wr(6'h1f, 16'h1235);
        rd(6'h1f, 16'h1235);
        for (int a = 'h21; a <= 'h26; a++) begin
            r = $random(seed);
            wr(a[5:0], r);
            rd(a[5:0], r);
        end
        wr(6'h20, 16'hffff);
        rd(6'h20, 16'h0005);
        chk({wdis, uscl}, 2'b11);
        for (int m = 0; m < 4; m++) begin
            wr(6'h27, m[15:0]);
            rd(6'h27, (m == 3) ? 16'h0002 : m[15:0]);
            chk(meth, (m == 3) ? 2'd2 : m[1:0]);
        end
        wr(6'h29, 16'h0001);
        rd(6'h29, 16'h0001);
        chk(f60, 1'b1);
        wr(6'h07, 16'h7000);
        for (int a = 'h21; a <= 'h29; a++) begin
            rd(a[5:0], dflt(a[5:0]));
        end
        wr(6'h22, 16'h0080);
        wr(6'h21, 16'h0003);
        r = $random(seed);
        wait_cv(r);
        chk(cv, scl(r, 16'h0080, 16'h0003));
        wr(6'h24, 16'h0002);
        wait_cv(r | 16'h0001);
        wr(6'h20, 16'h0000);
        repeat (5) @(negedge i_clk);
        chk(fe, 1'b0);
        repeat (9) @(negedge i_clk);
        chk(fe, 1'b1);
        chk(cv, 16'h3fff);
        wait_cv(16'h0000);
        chk(cv, 16'h0000);
        wr(6'h1f, 16'h0000);
        wr(6'h22, 16'h1234);
        rd(6'h22, 16'h0080);
        @(posedge i_clk);
        sc <= 1'b1;
        wait_cv(16'h0000);
        chk(sten, 1'b0);
        @(posedge i_clk);
        sc <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(sten, 1'b1);
        // Stay-off behaviour, then restart with protection re-armed.
        wr(6'h1f, 16'h1235);
        wr(6'h28, 16'h0000);
        @(posedge i_clk);
        sc <= 1'b1;
        @(posedge i_clk);
        sc <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(sten, 1'b0);
        @(posedge i_clk);
        i_srst <= 1'b1;
        @(posedge i_clk);
        i_srst <= 1'b0;
        rd(6'h1f, 16'h0000);
        final_report();
    end

    // Cuts a hang short.
    initial begin
        repeat (4000) @(posedge i_clk);
        errors++;
        final_report();
    end
endmodule

`default_nettype wire
